/* File: shared/sffd_pkg.sv */
// Constants, types and register map of the stepper frame field decoder
//------------------------------------------------------------------------
// Summary of operation
// - Initial byte six: low nibble preset one, high nibble preset two, ch A
// - Preset code maps to 200 mV plus 20 mV per step, up to 500 mV
// - Initial byte seven: same split and mapping for channel B presets
// - Nonzero sum inhibits stepping and drives the monitor output low
// - Standard byte one D0..D3: zero sinks aux output, one releases it
// - Bit D7 of bytes two and five: zero forward, one reverse
// - Bit D6 of bytes two and five: zero bridge off, one conducting
// - Bits D0..D5 of bytes two and five, doubled, give pulses per window
// - Channel A period: byte three low eight, byte four D0..D6 upper
// - Channel B period: byte six low eight, byte seven D0..D6 upper
// - Period count is in quarter-microsecond units of the 4 MHz clock
// - Bit D7 of standard byte four selects channel A preset
// - Bit D7 of standard byte seven selects channel B preset
// - Byte one D7..D5: 111 initial frame, 000 standard frame, else none
//------------------------------------------------------------------------
package sffd_pkg;

    //--------------------------------------------------------------------
    // Frame layout
    //--------------------------------------------------------------------
    localparam int          FRAME_BYTES   = 8;
    localparam logic [2:0]  TYPE_INITIAL  = 3'h7;
    localparam logic [2:0]  TYPE_STANDARD = 3'h0;
    localparam logic [8:0]  LVL_BASE_MV   = 9'h0c8;
    localparam logic [8:0]  LVL_STEP_MV   = 9'h014;
    localparam int          PERIOD_UNIT_NS = 250;

    //--------------------------------------------------------------------
    // Register map
    //--------------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_MASK    = 8'h08;
    localparam logic [7:0]  OFS_PRESETS = 8'h0c;
    localparam logic [7:0]  OFS_CHAN_A  = 8'h10;
    localparam logic [7:0]  OFS_CHAN_B  = 8'h14;
    localparam logic [7:0]  OFS_OUTS    = 8'h18;

    localparam int          CTRL_ENABLE_BIT = 0;
    localparam logic        CTRL_RESET      = 1'b1;
    localparam logic [3:0]  MASK_RESET      = 4'h0;

    localparam int          ST_FRAME_OK  = 0;
    localparam int          ST_CSUM_ERR  = 1;
    localparam int          ST_BAD_TYPE  = 2;
    localparam int          ST_LATE_STD  = 3;

    localparam int          CH_PULSE_POS = 16;
    localparam int          CH_EN_POS    = 24;
    localparam int          CH_DIR_POS   = 25;
    localparam int          CH_SEL_POS   = 26;

    //--------------------------------------------------------------------
    // Types
    //--------------------------------------------------------------------
    typedef struct packed {
        logic        dir;
        logic        enable;
        logic [6:0]  pulses;
        logic [14:0] period;
        logic        preset_sel;
        logic [8:0]  current_ref_level;
    } sffd_chan_t;

    typedef struct packed {
        logic [3:0] p1;
        logic [3:0] p2;
    } sffd_presets_t;

endpackage

/* File: design/sffd_top.sv */
// Serial frame receiver, decoder and APB register file
`timescale 1ns/1ps
module sffd_top (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ser_clk,
    input  wire logic              ser_data,
    input  wire logic              ser_sync,
    input  wire logic              wait_window_flag,
    output sffd_pkg::sffd_chan_t   chan_a,
    output sffd_pkg::sffd_chan_t   chan_b,
    output logic      [3:0]        aux_open_drain_out,
    output logic      [3:0]        aux_od_oe,
    output logic                   monitor_output,
    output logic                   step_inhibit,
    output logic                   irq
);
    import sffd_pkg::*;

    //--------------------------------------------------------------------
    // Serial capture
    //--------------------------------------------------------------------
    logic                ser_clk_q;
    logic [2:0]          bcnt_r;
    logic [2:0]          bidx_r;
    logic [7:0]          sh_r;
    logic [7:0]          sum_r;
    logic [7:0]          frm_r [FRAME_BYTES];
    logic                done_r;
    logic                ser_rise;
    logic [7:0]          newb;

    assign ser_rise = ser_clk & ~ser_clk_q;
    assign newb     = {ser_data, sh_r[7:1]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_clk_q <= 1'b0;
        end else begin
            ser_clk_q <= ser_clk;
        end
    end

    // Sync pulls the receiver back to bit zero of byte one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_r <= 3'h0;
            bidx_r <= 3'h0;
            sh_r   <= 8'h00;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (ser_sync) begin
                bcnt_r <= 3'h0;
                bidx_r <= 3'h0;
            end else if (ser_rise) begin
                sh_r   <= newb;
                bcnt_r <= bcnt_r + 3'h1;
                if (bcnt_r == 3'h7) begin
                    bidx_r <= bidx_r + 3'h1;
                    done_r <= (bidx_r == 3'h7);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_r <= 8'h00;
            for (int i = 0; i < FRAME_BYTES; i++) begin
                frm_r[i] <= 8'h00;
            end
        end else if (!ser_sync && ser_rise && bcnt_r == 3'h7) begin
            frm_r[bidx_r] <= newb;
            sum_r <= (bidx_r == 3'h0) ? newb : sum_r + newb;
        end
    end

    //--------------------------------------------------------------------
    // Frame classification
    //--------------------------------------------------------------------
    logic                ctrl_en_r;
    logic                sum_ok;
    logic                is_init;
    logic                is_std;
    logic                good_init;
    logic                good_std;

    assign sum_ok    = (sum_r == 8'h00);
    assign is_init   = (frm_r[0][7:5] == TYPE_INITIAL);
    assign is_std    = (frm_r[0][7:5] == TYPE_STANDARD);
    assign good_init = done_r & ctrl_en_r & sum_ok & is_init;
    assign good_std  = done_r & ctrl_en_r & sum_ok & is_std;

    //--------------------------------------------------------------------
    // Presets from the initial frame
    //--------------------------------------------------------------------
    sffd_presets_t       pre_a_r;
    sffd_presets_t       pre_b_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_a_r <= '0;
            pre_b_r <= '0;
        end else if (good_init) begin
            pre_a_r <= '{p1: frm_r[5][3:0], p2: frm_r[5][7:4]};
            pre_b_r <= '{p1: frm_r[6][3:0], p2: frm_r[6][7:4]};
        end
    end

    function automatic logic [8:0] lvl_mv(input logic [3:0] code);
        lvl_mv = LVL_BASE_MV + 9'(code) * LVL_STEP_MV;
    endfunction

    function automatic sffd_chan_t dec_chan(input logic [7:0] cfg,
                                            input logic [7:0] plo,
                                            input logic [7:0] phi,
                                            input sffd_presets_t pr);
        sffd_chan_t c;
        c.dir        = cfg[7];
        c.enable     = cfg[6];
        c.pulses     = {cfg[5:0], 1'b0};
        c.period     = {phi[6:0], plo};
        c.preset_sel = phi[7];
        c.current_ref_level = lvl_mv(phi[7] ? pr.p2 : pr.p1);
        dec_chan = c;
    endfunction

    //--------------------------------------------------------------------
    // Channel settings and outputs
    //--------------------------------------------------------------------
    // Checksum failures keep the previous settings; nothing half-applied
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_a <= '0;
            chan_b <= '0;
        end else if (good_std) begin
            chan_a <= dec_chan(frm_r[1], frm_r[2], frm_r[3],
                               pre_a_r);
            chan_b <= dec_chan(frm_r[4], frm_r[5], frm_r[6],
                               pre_b_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_open_drain_out <= 4'h0;
            aux_od_oe          <= 4'h0;
        end else begin
            aux_open_drain_out <= 4'h0;
            if (good_init || good_std) begin
                aux_od_oe <= ~frm_r[0][3:0];
            end
        end
    end

    // Error state persists until a frame with a clean sum arrives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            monitor_output <= 1'b1;
            step_inhibit   <= 1'b0;
        end else if (done_r && ctrl_en_r) begin
            monitor_output <= sum_ok;
            step_inhibit   <= ~sum_ok;
        end
    end

    //--------------------------------------------------------------------
    // Events and interrupt
    //--------------------------------------------------------------------
    logic [3:0]          sts_r;
    logic [3:0]          mask_r;
    logic [3:0]          ev_set;
    logic [3:0]          ev_clr;
    logic                wr_acc;

    assign wr_acc = psel & penable & pready & pwrite;
    assign ev_clr = (wr_acc && paddr == OFS_STATUS) ? pwdata[3:0] : 4'h0;

    always_comb begin
        ev_set = 4'h0;
        ev_set[ST_FRAME_OK] = good_init | good_std;
        ev_set[ST_CSUM_ERR] = done_r & ctrl_en_r & ~sum_ok;
        ev_set[ST_BAD_TYPE] = done_r & ctrl_en_r & ~is_init & ~is_std;
        // Host broke the window discipline; frame is still applied
        ev_set[ST_LATE_STD] = good_std & ~wait_window_flag;
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_r <= 4'h0;
        end else begin
            sts_r <= (sts_r & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((sts_r & ~ev_clr) | ev_set) & mask_r);
        end
    end

    //--------------------------------------------------------------------
    // APB slave
    //--------------------------------------------------------------------
    logic [31:0]         rd_nxt;
    logic                hit;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        hit    = 1'b1;
        case (paddr)
            OFS_CTRL:    rd_nxt[CTRL_ENABLE_BIT] = ctrl_en_r;
            OFS_STATUS:  rd_nxt[3:0] = sts_r;
            OFS_MASK:    rd_nxt[3:0] = mask_r;
            OFS_PRESETS: rd_nxt[15:0] = {pre_b_r, pre_a_r};
            OFS_CHAN_A: begin
                rd_nxt[14:0] = chan_a.period;
                rd_nxt[CH_PULSE_POS +: 7] = chan_a.pulses;
                rd_nxt[CH_EN_POS]  = chan_a.enable;
                rd_nxt[CH_DIR_POS] = chan_a.dir;
                rd_nxt[CH_SEL_POS] = chan_a.preset_sel;
            end
            OFS_CHAN_B: begin
                rd_nxt[14:0] = chan_b.period;
                rd_nxt[CH_PULSE_POS +: 7] = chan_b.pulses;
                rd_nxt[CH_EN_POS]  = chan_b.enable;
                rd_nxt[CH_DIR_POS] = chan_b.dir;
                rd_nxt[CH_SEL_POS] = chan_b.preset_sel;
            end
            OFS_OUTS:    rd_nxt[5:0] = {step_inhibit, monitor_output,
                                        aux_od_oe};
            default:     hit = 1'b0;
        endcase
    end

    // One setup, one access cycle; ready is a flop so outputs stay clean
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_nxt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_r <= CTRL_RESET;
            mask_r    <= MASK_RESET;
        end else if (wr_acc) begin
            if (paddr == OFS_CTRL) begin
                ctrl_en_r <= pwdata[CTRL_ENABLE_BIT];
            end
            if (paddr == OFS_MASK) begin
                mask_r <= pwdata[3:0];
            end
        end
    end

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    sequence s_good_std;
        done_r && ctrl_en_r && sum_r == 8'h00 && frm_r[0][7:5] == 3'h0;
    endsequence

    sequence s_good_init;
        done_r && ctrl_en_r && sum_r == 8'h00 && frm_r[0][7:5] == 3'h7;
    endsequence

    property p_preset_a;
        @(posedge pclk) disable iff (!presetn)
        s_good_init |=> pre_a_r == {$past(frm_r[5][3:0]),
                                    $past(frm_r[5][7:4])};
    endproperty
    a_preset_a: assert property (p_preset_a)
        else $error("channel A presets not taken from byte six");

    property p_preset_b;
        @(posedge pclk) disable iff (!presetn)
        s_good_init |=> pre_b_r == {$past(frm_r[6][3:0]),
                                    $past(frm_r[6][7:4])};
    endproperty
    a_preset_b: assert property (p_preset_b)
        else $error("channel B presets not taken from byte seven");

    property p_level;
        @(posedge pclk) disable iff (!presetn)
        chan_a.current_ref_level >= 9'd200 &&
        chan_a.current_ref_level <= 9'd500 ||
        chan_a == '0;
    endproperty
    a_level: assert property (p_level)
        else $error("reference level out of range");

    property p_csum_err;
        @(posedge pclk) disable iff (!presetn)
        done_r && ctrl_en_r && sum_r != 8'h00 |=>
            !monitor_output && step_inhibit && $stable(chan_a);
    endproperty
    a_csum_err: assert property (p_csum_err)
        else $error("bad checksum did not inhibit stepping");

    property p_aux;
        @(posedge pclk) disable iff (!presetn)
        s_good_std |=> aux_od_oe == ~$past(frm_r[0][3:0]);
    endproperty
    a_aux: assert property (p_aux)
        else $error("aux enables do not follow byte one");

    property p_cfg_a;
        @(posedge pclk) disable iff (!presetn)
        s_good_std |=> chan_a.dir == $past(frm_r[1][7]) &&
            chan_a.enable == $past(frm_r[1][6]) &&
            chan_a.pulses == {$past(frm_r[1][5:0]), 1'b0};
    endproperty
    a_cfg_a: assert property (p_cfg_a)
        else $error("channel A direction, enable or pulses wrong");

    property p_period_a;
        @(posedge pclk) disable iff (!presetn)
        s_good_std |=> chan_a.period == {$past(frm_r[3][6:0]),
            $past(frm_r[2])} && chan_a.preset_sel == $past(frm_r[3][7]);
    endproperty
    a_period_a: assert property (p_period_a)
        else $error("channel A period or preset select wrong");

    property p_period_b;
        @(posedge pclk) disable iff (!presetn)
        s_good_std |=> chan_b.period == {$past(frm_r[6][6:0]),
            $past(frm_r[5])} && chan_b.preset_sel == $past(frm_r[6][7]);
    endproperty
    a_period_b: assert property (p_period_b)
        else $error("channel B period or preset select wrong");

    property p_bad_type;
        @(posedge pclk) disable iff (!presetn)
        done_r && frm_r[0][7:5] != 3'h0 && frm_r[0][7:5] != 3'h7 |=>
            $stable(chan_b) && $stable(pre_a_r);
    endproperty
    a_bad_type: assert property (p_bad_type)
        else $error("unknown frame type changed settings");

    property p_done_spacing;
        @(posedge pclk) disable iff (!presetn)
        done_r |=> !done_r [*8];
    endproperty
    a_done_spacing: assert property (p_done_spacing)
        else $error("frame end pulses too close together");

endmodule

/* File: verification/sffd_host_model.sv */
// Host model that sends eight-byte serial parameter frames
`timescale 1ns/1ps
module sffd_host_model (
    input  wire logic pclk,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_sync
);
    initial begin
        ser_clk  = 1'b0;
        ser_data = 1'b0;
        ser_sync = 1'b0;
    end

    //--------------------------------------------------------------------
    // Frame transmission
    //--------------------------------------------------------------------
    // Byte one sits lowest in b; half sets the bit pace, prompt or slow
    task automatic send_frame(input logic [55:0] b, input logic bad,
                              input int half);
        logic [63:0] f;
        logic [7:0]  sum;
        sum = 8'h00;
        for (int k = 0; k < 7; k++) begin
            sum = sum + b[8*k +: 8];
        end
        f = {8'h00 - sum + {7'h00, bad}, b};
        @(posedge pclk);
        ser_sync <= 1'b1;
        @(posedge pclk);
        ser_sync <= 1'b0;
        for (int i = 0; i < 64; i++) begin
            @(posedge pclk);
            ser_clk  <= 1'b0;
            ser_data <= f[i];
            repeat (half) @(posedge pclk);
            ser_clk <= 1'b1;
            repeat (half) @(posedge pclk);
        end
        // Clock stands low between frames; no pull on data, so invert it
        ser_clk  <= 1'b0;
        ser_data <= ~f[63];
    endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the stepper frame field decoder
`timescale 1ns/1ps
module tb_top;
    import sffd_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic        ser_clk, ser_data, ser_sync, wait_window_flag;
    logic        monitor_output, step_inhibit, irq, e;
    logic [3:0]  aux_open_drain_out, aux_od_oe, exp_oe, exp_st, mask;
    sffd_chan_t  chan_a, chan_b, exp_a, exp_b;
    logic        exp_mon, exp_inh, ctrl_en, lvl_ok;
    logic [55:0] b;
    int          failures, total_checks, pa1, pa2, pb1, pb2;

    sffd_top sffd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ser_clk(ser_clk), .ser_data(ser_data), .ser_sync(ser_sync),
        .wait_window_flag(wait_window_flag), .chan_a(chan_a),
        .chan_b(chan_b), .aux_open_drain_out(aux_open_drain_out),
        .aux_od_oe(aux_od_oe), .monitor_output(monitor_output),
        .step_inhibit(step_inhibit), .irq(irq));
    sffd_host_model sffd_host_model_i (.pclk(pclk), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_sync(ser_sync));

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    //--------------------------------------------------------------------
    // Compare and closing tasks
    //--------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask

    // Level part compared only when asked for by the caller
    task automatic chk_chan(input string nm, input sffd_chan_t x,
                            input sffd_chan_t g, input logic lvl);
        total_checks++;
        if (g[33:9] !== x[33:9] || (lvl && g[8:0] !== x[8:0])) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    //--------------------------------------------------------------------
    // APB master
    //--------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, wd, r, x);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] x);
        logic [31:0] r;
        logic        er;
        apb(1'b0, a, 32'h0, r, er);
        chk(nm, x, r);
        chk("pslverr", 32'h0, {31'h0, er});
    endtask

    //--------------------------------------------------------------------
    // Reference model
    //--------------------------------------------------------------------
    function automatic sffd_chan_t mk(input logic [7:0] c, lo, hi,
                                      input int p1, p2);
        sffd_chan_t r;
        r.dir        = c[7];
        r.enable     = c[6];
        r.pulses     = {c[5:0], 1'b0};
        r.period     = {hi[6:0], lo};
        r.preset_sel = hi[7];
        r.current_ref_level = 9'(200 + 20 * (hi[7] ? p2 : p1));
        return r;
    endfunction

    task automatic frame(input logic [55:0] f, input logic bad,
                         input int half, input logic ww);
        wait_window_flag <= ww;
        sffd_host_model_i.send_frame(f, bad, half);
        repeat (4) @(posedge pclk);
        exp_st = 4'h0;
        if (!ctrl_en) begin
            exp_st = 4'h0;
        end else if (bad) begin
            exp_mon = 1'b0;
            exp_inh = 1'b1;
            exp_st  = 4'h2;
        end else if (f[7:5] == 3'h7) begin
            exp_oe = ~f[3:0];
            pa1 = f[43:40];
            pa2 = f[47:44];
            pb1 = f[51:48];
            pb2 = f[55:52];
            {exp_mon, exp_inh, exp_st, lvl_ok} = {2'b10, 4'h1, 1'b1};
        end else if (f[7:5] == 3'h0) begin
            exp_oe = ~f[3:0];
            exp_a = mk(f[15:8], f[23:16], f[31:24], pa1, pa2);
            exp_b = mk(f[39:32], f[47:40], f[55:48], pb1, pb2);
            {exp_mon, exp_inh, exp_st, lvl_ok} = {2'b10, ~ww, 3'h1, 1'b1};
        end else begin
            {exp_mon, exp_inh} = 2'b10;
            exp_st = 4'h4;
        end
        chk_chan("chan_a", exp_a, chan_a, lvl_ok);
        chk_chan("chan_b", exp_b, chan_b, lvl_ok);
        chk("aux_od_oe", 32'(exp_oe), 32'(aux_od_oe));
        chk("aux_out", 32'h0, 32'(aux_open_drain_out));
        chk("monitor", 32'(exp_mon), 32'(monitor_output));
        chk("inhibit", 32'(exp_inh), 32'(step_inhibit));
        chk("irq", 32'(|(exp_st & mask)), 32'(irq));
        rd_chk("status", OFS_STATUS, 32'(exp_st));
        d = 32'({4'(pb1), 4'(pb2), 4'(pa1), 4'(pa2)});
        rd_chk("presets", OFS_PRESETS, d);
        rd_chk("outs", OFS_OUTS, 32'({exp_inh, exp_mon, exp_oe}));
        d = 32'({exp_a.preset_sel, exp_a.dir, exp_a.enable, 1'b0,
                 exp_a.pulses, 1'b0, exp_a.period});
        rd_chk("chan_a_reg", OFS_CHAN_A, d);
        d = 32'({exp_b.preset_sel, exp_b.dir, exp_b.enable, 1'b0,
                 exp_b.pulses, 1'b0, exp_b.period});
        rd_chk("chan_b_reg", OFS_CHAN_B, d);
        wr(OFS_STATUS, 32'hf);
        rd_chk("status_clr", OFS_STATUS, 32'h0);
        chk("irq_clr", 32'h0, 32'(irq));
    endtask

    //--------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        wait_window_flag = 1'b0;
        {exp_a, exp_b, exp_oe, mask, exp_inh} = '0;
        {exp_mon, ctrl_en, lvl_ok} = 3'b111;
        {pa1, pa2, pb1, pb2} = {0, 0, 0, 0};
        void'($urandom(85707));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_chan("rst_a", exp_a, chan_a, 1'b1);
        chk("rst_mon", 32'h1, 32'(monitor_output));
        chk("rst_inh_irq", 32'h0, 32'({step_inhibit, irq}));
        rd_chk("ctrl", OFS_CTRL, 32'h1);
        rd_chk("mask", OFS_MASK, 32'h0);
        apb(1'b0, 8'h40, 32'h0, d, e);
        chk("unmapped_data", 32'h0, d);
        chk("unmapped_err", 32'h1, 32'(e));
        frame({56'hf03c0208_1010e5}, 1'b0, 2, 1'b1);
        frame({56'h0001_40ff_ffff_0a}, 1'b0, 5, 1'b1);
        mask = 4'h2;
        wr(OFS_MASK, 32'h2);
        rd_chk("mask_rb", OFS_MASK, 32'h2);
        frame({56'h8034857f_122103}, 1'b1, 2, 1'b1);
        mask = 4'hf;
        wr(OFS_MASK, 32'hf);
        frame({56'h5aa50208_1010ef}, 1'b0, 3, 1'b1);
        frame({56'h11223344_55664f}, 1'b0, 2, 1'b1);
        frame({56'h80009e00_008106}, 1'b0, 2, 1'b0);
        ctrl_en = 1'b0;
        wr(OFS_CTRL, 32'h0);
        frame({56'h7fffc111_22330c}, 1'b0, 2, 1'b1);
        ctrl_en = 1'b1;
        wr(OFS_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) begin
            b = 56'({$urandom(), $urandom()});
            b[7:4] = 4'h0;
            frame(b, 1'b0, 2 + ($urandom() % 4), 1'b1);
        end
        conclude();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        $display("ERROR watchdog expected done seen timeout");
        conclude();
    end
endmodule
